/* src/flash_spec_defines.vh */
// Register offsets, field positions, reset values and codes of the speculative read-ahead unit
`ifndef FLASH_SPEC_DEFINES_VH
`define FLASH_SPEC_DEFINES_VH

// Register byte offsets
`define BANK0_CTRL_OFFSET     12'h000
`define BANK1_CTRL_OFFSET     12'h004
`define SPEC_STATUS_OFFSET    12'h008

// Control register fields
`define CTRL_BUF_EN_BIT       0
`define CTRL_INSTR_PF_BIT     1
`define CTRL_DATA_PF_BIT      2
`define CTRL_INV_WAY_LSB      20
`define CTRL_INV_WAY_MSB      23
`define CTRL_RESET_VALUE      3'h7

// Status register fields
`define STAT_STATE_LSB        0
`define STAT_FETCH_DROP_BIT   3
`define STAT_FETCH_SPEC_BIT   4
`define STAT_FETCH_BUSY_BIT   5
`define STAT_CUR_VALID_BIT    6
`define STAT_SPEC_VALID_BIT   7

// AXI4-Lite response codes
`define AXI_RESP_OKAY         2'h0
`define AXI_RESP_SLVERR       2'h2

`endif

/* src/phrase_store.v */
// Two-phrase storage (current and speculative) with a registered longword read port
`timescale 1ns/100ps

module phrase_store #(
   parameter ENTRIES = 2
) (
   // Clock
   input  wire        mclk,
   // Phrase write
   input  wire        wrEn,
   input  wire        wrEntry,
   input  wire [63:0] wrData,
   // Longword read
   input  wire        rdEn,
   input  wire [1:0]  rdAddr,
   output reg  [31:0] rdData
);

   reg [31:0] words [0:2*ENTRIES-1];

   always @(posedge mclk) begin
      if (wrEn) begin
         words[{wrEntry, 1'b0}] <= wrData[31:0];
         words[{wrEntry, 1'b1}] <= wrData[63:32];
      end
      // Write-first so a phrase landing in the cycle it is asked for is not stale
      if (rdEn) begin
         if (wrEn && (wrEntry == rdAddr[1]))
            rdData <= rdAddr[0] ? wrData[63:32] : wrData[31:0];
         else
            rdData <= words[rdAddr];
      end
   end

endmodule

/* src/flash_spec_prefetch.v */
// Speculative read-ahead of the flash acceleration unit with its AXI4-Lite control slave
//
// The placing of the registers and the AXI4-Lite slave port were decided locally.
`timescale 1ns/100ps
`include "flash_spec_defines.vh"

module flash_spec_prefetch #(
   parameter ADDR_W = 20,
   parameter AXI_AW = 12
) (
   // Clock and reset
   input  wire              mclk,
   input  wire              reset,
   // AXI4-Lite write
   input  wire [AXI_AW-1:0] awaddr,
   input  wire              awvalid,
   output reg               awready,
   input  wire [31:0]       wdata,
   input  wire [3:0]        wstrb,
   input  wire              wvalid,
   output reg               wready,
   output reg  [1:0]        bresp,
   output reg               bvalid,
   input  wire              bready,
   // AXI4-Lite read
   input  wire [AXI_AW-1:0] araddr,
   input  wire              arvalid,
   output reg               arready,
   output reg  [31:0]       rdata,
   output reg  [1:0]        rresp,
   output reg               rvalid,
   input  wire              rready,
   // Master read requests
   input  wire              reqValid,
   input  wire [ADDR_W-1:0] reqAddr,
   input  wire              reqInstr,
   output reg               reqReady,
   output reg               rspValid,
   output wire [31:0]       rspData,
   // Flash array
   output reg               flashReq,
   output reg  [ADDR_W-4:0] flashAddr,
   input  wire              flashAck,
   input  wire [63:0]       flashData
);

   localparam TAG_W  = ADDR_W - 3;
   localparam S_IDLE = 2'h0;
   localparam S_WAIT = 2'h1;
   localparam S_READ = 2'h2;

   // Prefetch enable for the bank and access type
   function pfOn;
      input [2:0] c0;
      input [2:0] c1;
      input       bank;
      input       instr;
      reg   [2:0] c;
      begin
         c = bank ? c1 : c0;
         pfOn = instr ? c[`CTRL_INSTR_PF_BIT] : c[`CTRL_DATA_PF_BIT];
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Registers

   reg [2:0]        bank0Ctrl_q;
   reg [2:0]        bank1Ctrl_q;
   reg              awHeld_q;
   reg              wHeld_q;
   reg [AXI_AW-1:0] awAddr_q;
   reg [31:0]       wData_q;
   reg [3:0]        wStrb_q;
   reg              invalidate;

   wire doWrite = awHeld_q && wHeld_q && !bvalid;
   wire wrBank0 = awAddr_q == `BANK0_CTRL_OFFSET;
   wire wrBank1 = awAddr_q == `BANK1_CTRL_OFFSET;
   wire wrStat  = awAddr_q == `SPEC_STATUS_OFFSET;

   // Any way bit written to bank 0 control flushes everything held here, since ways map onto no phrase
   always @* begin
      invalidate = doWrite && wrBank0 && wStrb_q[2]
                   && (wData_q[`CTRL_INV_WAY_MSB:`CTRL_INV_WAY_LSB] != 4'h0);
   end

   always @(posedge mclk) begin
      if (reset) begin
         awready     <= 1'b1;
         wready      <= 1'b1;
         awHeld_q    <= 1'b0;
         wHeld_q     <= 1'b0;
         awAddr_q    <= {AXI_AW{1'b0}};
         wData_q     <= 32'h0000_0000;
         wStrb_q     <= 4'h0;
         bvalid      <= 1'b0;
         bresp       <= `AXI_RESP_OKAY;
         bank0Ctrl_q <= `CTRL_RESET_VALUE;
         bank1Ctrl_q <= `CTRL_RESET_VALUE;
      end else begin
         if (awvalid && awready) begin
            awHeld_q <= 1'b1;
            awready  <= 1'b0;
            awAddr_q <= awaddr;
         end
         if (wvalid && wready) begin
            wHeld_q <= 1'b1;
            wready  <= 1'b0;
            wData_q <= wdata;
            wStrb_q <= wstrb;
         end
         if (doWrite) begin
            awHeld_q <= 1'b0;
            wHeld_q  <= 1'b0;
            bvalid   <= 1'b1;
            bresp    <= (wrBank0 || wrBank1 || wrStat) ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
            if (wrBank0 && wStrb_q[0])
               bank0Ctrl_q <= wData_q[2:0];
            if (wrBank1 && wStrb_q[0])
               bank1Ctrl_q <= wData_q[2:0];
         end
         if (bvalid && bready) begin
            bvalid  <= 1'b0;
            awready <= 1'b1;
            wready  <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Read-ahead state

   reg [1:0]       state_q, state_d;
   reg [TAG_W-1:0] pTag_q, pTag_d;
   reg             pHalf_q, pHalf_d;
   reg             curSel_q, curSel_d;
   reg             curValid_q, curValid_d;
   reg [TAG_W-1:0] curTag_q, curTag_d;
   reg             specValid_q, specValid_d;
   reg [TAG_W-1:0] specTag_q, specTag_d;
   reg             pfEn_q, pfEn_d;
   reg             fSpec_q, fSpec_d;
   reg             fDrop_q, fDrop_d;
   reg             fReq_d;
   reg [TAG_W-1:0] fAddr_d;
   reg             memWe;
   reg             rdEn;
   reg [1:0]       rdAddr;
   reg             reqBank;

   wire [TAG_W-1:0] reqTag = reqAddr[ADDR_W-1:3];
   wire             accept = reqValid && reqReady;
   wire             ackNow = flashReq && flashAck;

   always @* begin
      state_d     = state_q;
      pTag_d      = pTag_q;
      pHalf_d     = pHalf_q;
      curSel_d    = curSel_q;
      curValid_d  = curValid_q;
      curTag_d    = curTag_q;
      specValid_d = specValid_q;
      specTag_d   = specTag_q;
      pfEn_d      = pfEn_q;
      fSpec_d     = fSpec_q;
      fDrop_d     = fDrop_q;
      fReq_d      = flashReq;
      fAddr_d     = flashAddr;
      memWe       = 1'b0;
      rdEn        = 1'b0;
      rdAddr      = {curSel_q, pHalf_q};
      reqBank     = reqAddr[ADDR_W-1];

      // Fetch completion; the fill always lands in the non-current entry
      if (ackNow) begin
         fReq_d = 1'b0;
         if (fDrop_q) begin
            fDrop_d = 1'b0;
            if (state_q == S_WAIT) begin
               fReq_d  = 1'b1;
               fAddr_d = pTag_q;
               fSpec_d = 1'b0;
            end
         end else begin
            memWe = 1'b1;
            if (state_q == S_WAIT) begin
               curSel_d   = ~curSel_q;
               curTag_d   = flashAddr;
               curValid_d = pTag_q[TAG_W-1] ? bank1Ctrl_q[`CTRL_BUF_EN_BIT]
                                            : bank0Ctrl_q[`CTRL_BUF_EN_BIT];
               state_d    = S_READ;
            end else begin
               specValid_d = 1'b1;
               specTag_d   = flashAddr;
            end
         end
      end

      if (state_q == S_READ) begin
         rdEn    = 1'b1;
         state_d = S_IDLE;
      end else if (accept) begin
         pTag_d  = reqTag;
         pHalf_d = reqAddr[2];
         pfEn_d  = pfOn(bank0Ctrl_q, bank1Ctrl_q, reqBank, reqInstr);
         if (curValid_q && curTag_q == reqTag) begin
            rdEn   = 1'b1;
            rdAddr = {curSel_q, reqAddr[2]};
         end else if (specValid_d && specTag_d == reqTag) begin
            rdEn        = 1'b1;
            rdAddr      = {~curSel_q, reqAddr[2]};
            curSel_d    = ~curSel_q;
            curTag_d    = reqTag;
            curValid_d  = 1'b1;
            specValid_d = 1'b0;
         end else begin
            curValid_d  = 1'b0;
            specValid_d = 1'b0;
            state_d     = S_WAIT;
            if (fReq_d) begin
               // A fetch in flight cannot be aborted; reuse it or discard it
               if (!(fSpec_d && fAddr_d == reqTag))
                  fDrop_d = 1'b1;
            end else begin
               fReq_d  = 1'b1;
               fAddr_d = reqTag;
               fSpec_d = 1'b0;
            end
         end
      end

      if (invalidate) begin
         curValid_d  = 1'b0;
         specValid_d = 1'b0;
         if (fReq_d && fSpec_d)
            fDrop_d = 1'b1;
      end

      // Launch read-ahead as soon as the flash side is free
      if (!fReq_d && state_d != S_WAIT && curValid_d && !specValid_d && pfEn_d
          && !invalidate) begin
         fReq_d  = 1'b1;
         fAddr_d = curTag_d + {{(TAG_W-1){1'b0}}, 1'b1};
         fSpec_d = 1'b1;
      end
   end

   always @(posedge mclk) begin
      if (reset) begin
         state_q     <= S_IDLE;
         pTag_q      <= {TAG_W{1'b0}};
         pHalf_q     <= 1'b0;
         curSel_q    <= 1'b0;
         curValid_q  <= 1'b0;
         curTag_q    <= {TAG_W{1'b0}};
         specValid_q <= 1'b0;
         specTag_q   <= {TAG_W{1'b0}};
         pfEn_q      <= 1'b0;
         fSpec_q     <= 1'b0;
         fDrop_q     <= 1'b0;
         flashReq    <= 1'b0;
         flashAddr   <= {TAG_W{1'b0}};
         reqReady    <= 1'b1;
         rspValid    <= 1'b0;
      end else begin
         state_q     <= state_d;
         pTag_q      <= pTag_d;
         pHalf_q     <= pHalf_d;
         curSel_q    <= curSel_d;
         curValid_q  <= curValid_d;
         curTag_q    <= curTag_d;
         specValid_q <= specValid_d;
         specTag_q   <= specTag_d;
         pfEn_q      <= pfEn_d;
         fSpec_q     <= fSpec_d;
         fDrop_q     <= fDrop_d;
         flashReq    <= fReq_d;
         flashAddr   <= fAddr_d;
         reqReady    <= state_d == S_IDLE;
         rspValid    <= rdEn;
      end
   end

   phrase_store #(
      .ENTRIES (2)
   ) store (
      .mclk    (mclk),
      .wrEn    (memWe),
      .wrEntry (~curSel_q),
      .wrData  (flashData),
      .rdEn    (rdEn),
      .rdAddr  (rdAddr),
      .rdData  (rspData)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Register read

   always @(posedge mclk) begin
      if (reset) begin
         arready <= 1'b1;
         rvalid  <= 1'b0;
         rdata   <= 32'h0000_0000;
         rresp   <= `AXI_RESP_OKAY;
      end else if (arvalid && arready) begin
         arready <= 1'b0;
         rvalid  <= 1'b1;
         rresp   <= `AXI_RESP_OKAY;
         rdata   <= 32'h0000_0000;
         if (araddr == `BANK0_CTRL_OFFSET)
            rdata[2:0] <= bank0Ctrl_q;
         else if (araddr == `BANK1_CTRL_OFFSET)
            rdata[2:0] <= bank1Ctrl_q;
         else if (araddr == `SPEC_STATUS_OFFSET) begin
            rdata[`STAT_STATE_LSB+1:`STAT_STATE_LSB] <= state_q;
            rdata[`STAT_FETCH_DROP_BIT] <= fDrop_q;
            rdata[`STAT_FETCH_SPEC_BIT] <= fSpec_q;
            rdata[`STAT_FETCH_BUSY_BIT] <= flashReq;
            rdata[`STAT_CUR_VALID_BIT]  <= curValid_q;
            rdata[`STAT_SPEC_VALID_BIT] <= specValid_q;
         end else
            rresp <= `AXI_RESP_SLVERR;
      end else if (rvalid && rready) begin
         rvalid  <= 1'b0;
         arready <= 1'b1;
      end
   end

endmodule

/* sim/flash_model.sv */
// Flash array model answering phrase reads after a chosen latency
`timescale 1ns/100ps

module flash_model #(
   parameter AW = 17
) (
   // Clock and reset
   input  wire          mclk,
   input  wire          reset,
   // Phrase read port
   input  wire          flashReq,
   input  wire [AW-1:0] flashAddr,
   input  wire [3:0]    lat,
   output reg           flashAck,
   output reg  [63:0]   flashData
);
   reg [3:0] cnt_q;

   always @(posedge mclk) begin
      if (reset) begin
         flashAck  <= 1'b0;
         cnt_q     <= 4'h0;
         flashData <= 64'h0;
      end else if (flashReq && !flashAck && cnt_q >= lat) begin
         flashAck  <= 1'b1;
         flashData <= {15'h1234, flashAddr, 15'h4321, flashAddr};
         cnt_q     <= 4'h0;
      end else begin
         // Data churns outside the ack beat so stale values never look valid
         flashAck  <= 1'b0;
         flashData <= ~flashData;
         cnt_q     <= (flashReq && !flashAck) ? cnt_q + 4'h1 : 4'h0;
      end
   end
endmodule

/* sim/flash_spec_prefetch_monitor.sv */
// Port timing checker of the speculative read-ahead unit
`timescale 1ns/100ps

module flash_spec_prefetch_monitor #(
   parameter ADDR_W = 20,
   parameter AXI_AW = 12
) (
   // Clock and reset
   input wire              mclk,
   input wire              reset,
   // Register bus
   input wire              awvalid,
   input wire              awready,
   input wire              wvalid,
   input wire              wready,
   input wire              bvalid,
   input wire              bready,
   input wire [1:0]        bresp,
   input wire              arvalid,
   input wire              arready,
   input wire              rvalid,
   input wire              rready,
   input wire [31:0]       rdata,
   // Master and flash sides
   input wire              reqValid,
   input wire              reqReady,
   input wire              rspValid,
   input wire              flashReq,
   input wire [ADDR_W-4:0] flashAddr,
   input wire              flashAck
);
   default clocking dcb @(posedge mclk); endclocking
   default disable iff (reset);

   hit_answer_a: assert property (reqValid && reqReady ##1 reqReady |-> rspValid)
      else $error("hit not answered in one cycle");
   miss_answer_a: assert property ($rose(reqReady) |-> rspValid)
      else $error("miss answer late");
   flash_hold_a: assert property (flashReq && !flashAck |=> flashReq && $stable(flashAddr))
      else $error("flash request dropped early");
   wr_answer_a: assert property (awvalid && awready && wvalid && wready |=> !awready ##1 bvalid)
      else $error("write response timing");
   b_stand_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write response not held");
   rd_answer_a: assert property (arvalid && arready |=> rvalid && !arready)
      else $error("read response timing");
   r_stand_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
      else $error("read data not held");
   reset_state_a: assert property (disable iff (1'b0) reset |=> reqReady && !flashReq && !rspValid)
      else $error("reset state wrong");
endmodule

/* sim/tb_top.sv */
// Self-checking bench of the speculative read-ahead unit
`timescale 1ns/100ps
`include "flash_spec_defines.vh"

module tb_top;
   localparam ADDR_W = 20;
   localparam AXI_AW = 12;
   reg               mclk, reset, awvalid, wvalid, bready, arvalid, rready;
   reg               reqValid, reqInstr, ackSeen_q, postReq;
   reg  [AXI_AW-1:0] awaddr, araddr;
   reg  [31:0]       wdata;
   reg  [3:0]        wstrb, lat;
   reg  [ADDR_W-1:0] reqAddr, base;
   reg  [ADDR_W-4:0] postAddr;
   wire              awready, wready, bvalid, arready, rvalid;
   wire              reqReady, rspValid, flashReq, flashAck;
   wire [1:0]        bresp, rresp;
   wire [31:0]       rdata, rspData;
   wire [ADDR_W-4:0] flashAddr;
   wire [63:0]       flashData;
   integer           errors, n_tests, cycles, lt, i, k;

   flash_spec_prefetch #(.ADDR_W(ADDR_W), .AXI_AW(AXI_AW)) dut_u (
      .mclk(mclk), .reset(reset),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .reqValid(reqValid), .reqAddr(reqAddr), .reqInstr(reqInstr),
      .reqReady(reqReady), .rspValid(rspValid), .rspData(rspData),
      .flashReq(flashReq), .flashAddr(flashAddr), .flashAck(flashAck),
      .flashData(flashData)
   );
   flash_model #(.AW(ADDR_W-3)) flash_u (
      .mclk(mclk), .reset(reset), .flashReq(flashReq), .flashAddr(flashAddr),
      .lat(lat), .flashAck(flashAck), .flashData(flashData)
   );

   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end

   // Remember what the unit asked of flash right after each completed fetch
   always @(posedge mclk) begin
      if (reset) begin
         ackSeen_q <= 1'b0;
         postReq   <= 1'b0;
         postAddr  <= {(ADDR_W-3){1'b0}};
      end else begin
         ackSeen_q <= flashAck;
         if (ackSeen_q) begin
            postReq  <= flashReq;
            postAddr <= flashAddr;
         end
      end
   end

   always @(posedge mclk) begin
      cycles = cycles + 1;
      if (cycles == 20000) begin
         errors = errors + 1;
         $display("[FAIL] %0t timeout", $time);
         summarize;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   function [31:0] lw(input [19:0] a);
      lw = a[2] ? {15'h1234, a[19:3]} : {15'h4321, a[19:3]};
   endfunction

   task check(input [63:0] seen, input [63:0] exp);
      begin
         n_tests = n_tests + 1;
         if (seen !== exp) begin
            errors = errors + 1;
            $display("[FAIL] %0t mismatch seen %0h exp %0h", $time, seen, exp);
         end
      end
   endtask

   task axiWr(input [11:0] a, input [31:0] d, input [1:0] er);
      begin
         awaddr  <= a;
         wdata   <= d;
         awvalid <= 1'b1;
         wvalid  <= 1'b1;
         bready  <= 1'b1;
         @(posedge mclk);
         while (awvalid || wvalid) begin
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            @(posedge mclk);
         end
         while (!bvalid) @(posedge mclk);
         check(bresp, er);
         bready <= 1'b0;
         // Let an edge pass so a following call never re-raises bready in this step
         @(posedge mclk);
      end
   endtask

   task axiRd(input [11:0] a, input [31:0] ed, input [1:0] er);
      begin
         araddr  <= a;
         arvalid <= 1'b1;
         rready  <= 1'b1;
         @(posedge mclk);
         while (!arready) @(posedge mclk);
         arvalid <= 1'b0;
         while (!rvalid) @(posedge mclk);
         check(rdata, ed);
         check(rresp, er);
         rready <= 1'b0;
         @(posedge mclk);
      end
   endtask

   // Latency lt counts edges from the take to the answer
   task rd(input [19:0] a, input ins);
      begin
         reqAddr  <= a;
         reqInstr <= ins;
         reqValid <= 1'b1;
         @(posedge mclk);
         while (!reqReady) @(posedge mclk);
         reqValid <= 1'b0;
         lt = 0;
         do begin
            @(posedge mclk);
            lt = lt + 1;
         end while (!rspValid);
         check(rspData, lw(a));
      end
   endtask

   task summarize;
      begin
         $display("Comparisons %0d mismatches %0d", n_tests, errors);
         if (errors == 0 && n_tests > 0)
            $display("[ PASS ]");
         else
            $display("[ FAIL ]");
         $finish;
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////////////////
   initial begin
      {awvalid, wvalid, bready, arvalid, rready, reqValid, reqInstr} = 7'h00;
      {awaddr, araddr, wdata, reqAddr} = 76'h0;
      wstrb   = 4'hF;
      lat     = 4'h1;
      reset   = 1'b1;
      errors  = 0;
      n_tests = 0;
      cycles  = 0;
      k = $urandom(32'h3B1660D9);
      repeat (5) @(posedge mclk);
      reset <= 1'b0;
      @(posedge mclk);
      axiRd(`BANK0_CTRL_OFFSET, `CTRL_RESET_VALUE, `AXI_RESP_OKAY);
      axiRd(`BANK1_CTRL_OFFSET, `CTRL_RESET_VALUE, `AXI_RESP_OKAY);
      axiRd(`SPEC_STATUS_OFFSET, 32'h0, `AXI_RESP_OKAY);
      axiRd(12'h00C, 32'h0, `AXI_RESP_SLVERR);
      axiWr(12'h00C, 32'h0, `AXI_RESP_SLVERR);
      axiWr(`SPEC_STATUS_OFFSET, 32'h0, `AXI_RESP_OKAY);
      $display("register test done");
      // Four sequential longwords per pass, each bank and access type in turn
      for (i = 0; i < 8; i = i + 1) begin
         lat  <= 4'(($urandom % 6) + 1);
         base = (20'($urandom) & 20'h0FFF3) | {i[1], 19'h0};
         axiWr(`BANK0_CTRL_OFFSET, 32'h00F00007, `AXI_RESP_OKAY);
         rd(base, i[0]);
         check(lt > 1, 1'b1);
         check(postReq, 1'b1);
         check(postAddr, base[19:3] + 17'h1);
         rd(base + 20'h4, i[0]);
         check(lt, 1);
         rd(base + 20'h8, i[0]);
         rd(base + 20'hC, i[0]);
         check(lt, 1);
         rd(base, i[0]);
         check(lt > 1, 1'b1);
      end
      $display("sequential test done");
      // Each prefetch enable cleared alone must stop the read-ahead for its own traffic
      for (k = 0; k < 4; k = k + 1) begin
         base = (20'($urandom) & 20'h0FFF3) | {k[1], 19'h0};
         axiWr(`BANK0_CTRL_OFFSET, 32'h00F00007, `AXI_RESP_OKAY);
         axiWr(k[1] ? `BANK1_CTRL_OFFSET : `BANK0_CTRL_OFFSET, k[0] ? 32'h5 : 32'h3,
               `AXI_RESP_OKAY);
         axiRd(k[1] ? `BANK1_CTRL_OFFSET : `BANK0_CTRL_OFFSET, k[0] ? 32'h5 : 32'h3,
               `AXI_RESP_OKAY);
         rd(base, k[0]);
         check(postReq, 1'b0);
         rd(base ^ 20'h4, k[0]);
         check(lt, 1);
         axiWr(`BANK0_CTRL_OFFSET, 32'h00F00007, `AXI_RESP_OKAY);
         rd(base, k[0]);
         check(lt > 1, 1'b1);
         axiWr(k[1] ? `BANK1_CTRL_OFFSET : `BANK0_CTRL_OFFSET, 32'h7, `AXI_RESP_OKAY);
      end
      $display("enable test done");
      summarize;
   end
endmodule

bind flash_spec_prefetch flash_spec_prefetch_monitor #(.ADDR_W(ADDR_W), .AXI_AW(AXI_AW)) mon_u (
   .mclk(mclk), .reset(reset), .awvalid(awvalid), .awready(awready), .wvalid(wvalid),
   .wready(wready), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
   .arready(arready), .rvalid(rvalid), .rready(rready), .rdata(rdata),
   .reqValid(reqValid), .reqReady(reqReady), .rspValid(rspValid), .flashReq(flashReq),
   .flashAddr(flashAddr), .flashAck(flashAck)
);
